// *** verilog/pms_pkg.sv ***
// Purpose: Shared constants and types of the power-mode supervisor
// Assumes: 200 MHz main clock
// Notes:   Cycle counts derive from the times and the clock rate below
package pms_pkg;

   // Clock rate
   localparam int unsigned CLK_MHZ = 200;

   // Times as specified, in their own units
   localparam int unsigned T_UV_MS = 30;      // Under-voltage debounce, typical
   localparam int unsigned T_OV_US = 50;      // Load-dump debounce, least
   localparam int unsigned T_LINWK_US = 15;   // LIN dominant wake filter, least
   localparam int unsigned T_HVWK_US = 25;    // Pin wake filter, least
   localparam int unsigned T_POR_US = 500;    // Power-on startup, longest
   localparam int unsigned T_SLP_US = 250;    // Sleep-release startup, longest
   localparam int unsigned SLOW_OSC_HZ = 24000; // Idle clock rate

   // Cycle counts; all figures divide evenly at 200 MHz
   localparam int unsigned UV_CYC = T_UV_MS * CLK_MHZ * 1000;
   localparam int unsigned OV_CYC = T_OV_US * CLK_MHZ;
   localparam int unsigned LINWK_CYC = T_LINWK_US * CLK_MHZ;
   localparam int unsigned HVWK_CYC = T_HVWK_US * CLK_MHZ;
   localparam int unsigned POR_CYC = T_POR_US * CLK_MHZ;
   localparam int unsigned SLP_CYC = T_SLP_US * CLK_MHZ;

   // Under-voltage level select codes
   localparam logic [2:0] UV_SEL_RST = 3'h0;  // Lowest level, about 5 V
   localparam logic [2:0] UV_SEL_7V0 = 3'h4;
   localparam logic [2:0] UV_SEL_8V5 = 3'h7;

   // Number of high-voltage wake pins
   localparam int unsigned HV_PINS = 4;

   // Operating modes
   typedef enum logic [2:0] {
      PMS_OFF,
      PMS_START,
      PMS_NORMAL,
      PMS_IDLE,
      PMS_STOP,
      PMS_SLEEP
   } pms_mode_t;

endpackage

// *** verilog/pms_sync.sv ***
// Purpose: Three-stage input synchroniser with agreement check
// Assumes: Inputs are asynchronous to mclk_i
// Notes:   Output changes only once stages two and three agree
module pms_sync
   import pms_pkg::*;
#(
   parameter int unsigned W = 1
)
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // Data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   logic [W-1:0] s1_q, s2_q, s3_q, out_q;
   logic [W-1:0] out_d;

   // Accept a bit only where the last two stages agree
   always_comb
   begin
      out_d = out_q;
      for (int i = 0; i < W; i++)
      begin
         if (s2_q[i] == s3_q[i])
         begin
            out_d[i] = s3_q[i];
         end
      end
   end

   // Stage registers; first stage feeds only the second
   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         out_q <= '0;
      end
      else
      begin
         s1_q <= d_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         out_q <= out_d;
      end
   end

   assign q_o = out_q;

endmodule // pms_sync

// *** verilog/pms_filt.sv ***
// Purpose: Hold-time filter: pulse once a condition has held LIMIT cycles
// Assumes: cond_i is already synchronous
// Notes:   Counter restarts whenever the condition or the enable drops
module pms_filt
   import pms_pkg::*;
#(
   parameter int unsigned LIMIT = 16
)
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // Condition
   input wire logic en_i,
   input wire logic cond_i,
   output logic hit_o
);

   localparam int unsigned CW = $clog2(LIMIT + 1);
   localparam logic [CW-1:0] LIM = CW'(LIMIT);

   logic [CW-1:0] cnt_q, cnt_d;
   logic hit_q, hit_d;

   // Count while held; saturate so one hold gives exactly one pulse
   always_comb
   begin
      cnt_d = '0;
      hit_d = 1'b0;
      if (en_i && cond_i)
      begin
         if (cnt_q != LIM)
         begin
            cnt_d = cnt_q + CW'(1);
            hit_d = (cnt_q == LIM - CW'(1));
         end
         else
         begin
            cnt_d = cnt_q;
         end
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         cnt_q <= '0;
         hit_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         hit_q <= hit_d;
      end
   end

   assign hit_o = hit_q;

endmodule // pms_filt

// *** verilog/pms_top.sv ***
// Purpose: Power-mode supervisor: reset, idle, stop, sleep, wake and supply flags
// Assumes: One 200 MHz clock; analogue comparators and pins arrive asynchronously
// Notes:   Analogue and clock controls are levels driven to the surrounding logic
module pms_top
   import pms_pkg::*;
#(
   parameter int unsigned UV_CYCLES = UV_CYC,
   parameter int unsigned OV_CYCLES = OV_CYC,
   parameter int unsigned HVWK_CYCLES = HVWK_CYC,
   parameter int unsigned POR_CYCLES = POR_CYC,
   parameter int unsigned SLP_CYCLES = SLP_CYC
)
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // Analogue comparators and pins, asynchronous
   input wire logic supply_ok_i,
   input wire logic uv_det_i,
   input wire logic ov_det_i,
   input wire logic lin_rx_i,
   input wire logic [HV_PINS-1:0] high_voltage_pins_i,
   input wire logic ext_irq_i,
   // Software requests, one-cycle pulses
   input wire logic idle_req_i,
   input wire logic stop_req_i,
   input wire logic sleep_req_i,
   // Software flag control and configuration
   input wire logic uv_clr_i,
   input wire logic ov_clr_i,
   input wire logic uv_level_wr_i,
   input wire logic [2:0] uv_level_i,
   // Power and clock controls
   output logic regulators_en_o,
   output logic cpu_pwr_en_o,
   output logic digital_rst_b_o,
   output logic main_rc_oscillator_en_o,
   output logic slow_clk_sel_o,
   output logic periph_access_en_o,
   output logic lin_en_o,
   output logic auxiliary_wake_supply_only_o,
   // Status
   output pms_mode_t mode_o,
   output logic [2:0] undervoltage_level_select_o,
   output logic undervoltage_flag_o,
   output logic overvoltage_flag_o,
   output logic extended_irq_o
);

   localparam int unsigned SW = $clog2(POR_CYCLES + 1);
   localparam logic [SW-1:0] POR_LOAD = SW'(POR_CYCLES - 1);
   localparam logic [SW-1:0] SLP_LOAD = SW'(SLP_CYCLES - 1);

   // Synchronised inputs
   logic supply_ok_s, uv_s, ov_s, lin_s, ext_irq_s;
   logic [HV_PINS-1:0] hv_s;

   // Filter results
   logic uv_hit, ov_hit, lin_hit;
   logic [HV_PINS-1:0] hv_hit;

   // Mode state
   pms_mode_t mode_q, mode_d;
   logic [SW-1:0] start_cnt_q, start_cnt_d;

   // Flags and configuration
   logic uvf_q, uvf_d, ovf_q, ovf_d, irq_q, irq_d;
   logic [2:0] uv_sel_q, uv_sel_d;
   logic [HV_PINS-1:0] hv_ref_q, hv_ref_d;

   // Output registers
   logic reg_en_q, reg_en_d, cpu_pwr_q, cpu_pwr_d, rst_b_q, rst_b_d;
   logic osc_en_q, osc_en_d, slow_q, slow_d, periph_q, periph_d;
   logic lin_en_q, lin_en_d, aux_q, aux_d;

   // Supervisor watches supplies in normal, idle and stop modes, not during startup
   logic mon_en;
   logic in_sleep;
   logic wake_sleep;

   // Pins and comparators cross into the clock domain
   pms_sync #(.W(5 + HV_PINS)) u_sync (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .d_i({supply_ok_i, uv_det_i, ov_det_i, lin_rx_i, ext_irq_i, high_voltage_pins_i}),
      .q_o({supply_ok_s, uv_s, ov_s, lin_s, ext_irq_s, hv_s})
   );

   assign mon_en = (mode_q == PMS_NORMAL) || (mode_q == PMS_IDLE) || (mode_q == PMS_STOP);
   assign in_sleep = (mode_q == PMS_SLEEP);

   // Under-voltage debounce
   pms_filt #(.LIMIT(UV_CYCLES)) u_uv_filt (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .en_i(mon_en),
      .cond_i(uv_s),
      .hit_o(uv_hit)
   );

   // Load-dump debounce
   pms_filt #(.LIMIT(OV_CYCLES)) u_ov_filt (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .en_i(mon_en),
      .cond_i(ov_s),
      .hit_o(ov_hit)
   );

   // LIN wake: bus low is dominant
   pms_filt #(.LIMIT(LINWK_CYC)) u_lin_filt (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .en_i(in_sleep),
      .cond_i(!lin_s),
      .hit_o(lin_hit)
   );

   // Pin wake: any change from the settled level, either direction
   generate
      for (genvar g = 0; g < HV_PINS; g++)
      begin : g_hv
         pms_filt #(.LIMIT(HVWK_CYCLES)) u_hv_filt (
            .mclk_i(mclk_i),
            .rst_b_i(rst_b_i),
            .en_i(in_sleep),
            .cond_i(hv_s[g] != hv_ref_q[g]),
            .hit_o(hv_hit[g])
         );
      end
   endgenerate

   assign wake_sleep = lin_hit || (|hv_hit);

   // Pin reference follows the pins outside sleep so entry never wakes falsely
   always_comb
   begin
      hv_ref_d = hv_ref_q;
      if (!in_sleep)
      begin
         hv_ref_d = hv_s;
      end
   end

   // Mode sequencing
   always_comb
   begin
      mode_d = mode_q;
      start_cnt_d = start_cnt_q;
      if (!supply_ok_s)
      begin
         mode_d = PMS_OFF;
      end
      else
      begin
         case (mode_q)
            PMS_OFF:
            begin
               mode_d = PMS_START;
               start_cnt_d = POR_LOAD;
            end
            PMS_START:
            begin
               if (start_cnt_q == '0)
               begin
                  mode_d = PMS_NORMAL;
               end
               else
               begin
                  start_cnt_d = start_cnt_q - SW'(1);
               end
            end
            PMS_NORMAL:
            begin
               // Deepest request wins if several arrive together
               if (sleep_req_i)
               begin
                  mode_d = PMS_SLEEP;
               end
               else if (stop_req_i)
               begin
                  mode_d = PMS_STOP;
               end
               else if (idle_req_i)
               begin
                  mode_d = PMS_IDLE;
               end
            end
            PMS_IDLE, PMS_STOP:
            begin
               if (ext_irq_s)
               begin
                  mode_d = PMS_NORMAL;
               end
            end
            PMS_SLEEP:
            begin
               if (wake_sleep)
               begin
                  mode_d = PMS_START;
                  start_cnt_d = SLP_LOAD;
               end
            end
            default:
            begin
               mode_d = PMS_OFF;
            end
         endcase
      end
   end

   // Supply flags: a new event beats a clear in the same cycle
   always_comb
   begin
      uvf_d = uvf_q;
      ovf_d = ovf_q;
      uv_sel_d = uv_sel_q;
      if (uv_clr_i)
      begin
         uvf_d = 1'b0;
      end
      if (uv_hit)
      begin
         uvf_d = 1'b1;
      end
      if (ov_clr_i)
      begin
         ovf_d = 1'b0;
      end
      if (ov_hit)
      begin
         ovf_d = 1'b1;
      end
      if (uv_level_wr_i)
      begin
         uv_sel_d = uv_level_i;
      end
      if (mode_d == PMS_OFF || mode_d == PMS_START)
      begin
         // Whole chip is reset, so are the flags and the level
         uvf_d = 1'b0;
         ovf_d = 1'b0;
         uv_sel_d = UV_SEL_RST;
      end
      irq_d = uvf_d || ovf_d;
   end

   // Controls follow the next mode so they change with it
   always_comb
   begin
      reg_en_d = (mode_d != PMS_OFF);
      cpu_pwr_d = (mode_d != PMS_OFF) && (mode_d != PMS_SLEEP);
      aux_d = (mode_d == PMS_SLEEP);
      rst_b_d = (mode_d != PMS_OFF) && (mode_d != PMS_START) && (mode_d != PMS_SLEEP);
      osc_en_d = (mode_d == PMS_START) || (mode_d == PMS_NORMAL) || (mode_d == PMS_IDLE);
      slow_d = (mode_d == PMS_IDLE);
      periph_d = (mode_d == PMS_NORMAL);
      lin_en_d = (mode_d == PMS_NORMAL);
   end

   // State and output registers
   always_ff @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         mode_q <= PMS_OFF;
         start_cnt_q <= '0;
         uvf_q <= 1'b0;
         ovf_q <= 1'b0;
         irq_q <= 1'b0;
         uv_sel_q <= UV_SEL_RST;
         hv_ref_q <= '0;
         reg_en_q <= 1'b0;
         cpu_pwr_q <= 1'b0;
         aux_q <= 1'b0;
         rst_b_q <= 1'b0;
         osc_en_q <= 1'b0;
         slow_q <= 1'b0;
         periph_q <= 1'b0;
         lin_en_q <= 1'b0;
      end
      else
      begin
         mode_q <= mode_d;
         start_cnt_q <= start_cnt_d;
         uvf_q <= uvf_d;
         ovf_q <= ovf_d;
         irq_q <= irq_d;
         uv_sel_q <= uv_sel_d;
         hv_ref_q <= hv_ref_d;
         reg_en_q <= reg_en_d;
         cpu_pwr_q <= cpu_pwr_d;
         aux_q <= aux_d;
         rst_b_q <= rst_b_d;
         osc_en_q <= osc_en_d;
         slow_q <= slow_d;
         periph_q <= periph_d;
         lin_en_q <= lin_en_d;
      end
   end

   // Interrupt has its own register, loaded with the flags so it never glitches
   assign extended_irq_o = irq_q;
   assign undervoltage_flag_o = uvf_q;
   assign overvoltage_flag_o = ovf_q;
   assign undervoltage_level_select_o = uv_sel_q;
   assign mode_o = mode_q;
   assign regulators_en_o = reg_en_q;
   assign cpu_pwr_en_o = cpu_pwr_q;
   assign auxiliary_wake_supply_only_o = aux_q;
   assign digital_rst_b_o = rst_b_q;
   assign main_rc_oscillator_en_o = osc_en_q;
   assign slow_clk_sel_o = slow_q;
   assign periph_access_en_o = periph_q;
   assign lin_en_o = lin_en_q;

endmodule // pms_top

// *** test/pms_checker.sv ***
// Purpose: Concurrent checks on the power-mode supervisor ports
// Assumes: Counts match the parameters handed on by the bind
// Notes:   Debounce checks count raw input cycles, so sync delay only adds margin
module pms_checker
   import pms_pkg::*;
#(
   parameter int unsigned UV_CYCLES = UV_CYC,
   parameter int unsigned OV_CYCLES = OV_CYC,
   parameter int unsigned POR_CYCLES = POR_CYC,
   parameter int unsigned SLP_CYCLES = SLP_CYC
)
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // Block inputs
   input wire logic supply_ok_i,
   input wire logic uv_det_i,
   input wire logic ov_det_i,
   input wire logic ext_irq_i,
   input wire logic sleep_req_i,
   input wire logic uv_clr_i,
   // Block outputs
   input wire logic regulators_en_o,
   input wire logic cpu_pwr_en_o,
   input wire logic main_rc_oscillator_en_o,
   input wire logic slow_clk_sel_o,
   input wire logic periph_access_en_o,
   input wire logic lin_en_o,
   input wire pms_mode_t mode_o,
   input wire logic [2:0] undervoltage_level_select_o,
   input wire logic undervoltage_flag_o,
   input wire logic overvoltage_flag_o,
   input wire logic extended_irq_o
);
   timeunit 1ns;
   timeprecision 100ps;
   int unsigned uv_run_q, uv_run_d, ov_run_q, ov_run_d, st_cnt_q, st_cnt_d;
   logic slp_q, slp_d;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   // Run lengths of the raw comparators and of the startup phase
   always_comb
   begin
      uv_run_d = uv_det_i ? uv_run_q + 1 : 0;
      ov_run_d = ov_det_i ? ov_run_q + 1 : 0;
      st_cnt_d = (mode_o == PMS_START) ? st_cnt_q + 1 : 0;
      slp_d = (mode_o == PMS_SLEEP) || (slp_q && mode_o == PMS_START);
   end
   // A startup after sleep is held to the shorter limit
   always_ff @(posedge mclk_i)
   begin
      uv_run_q <= rst_b_i ? uv_run_d : 0;
      ov_run_q <= rst_b_i ? ov_run_d : 0;
      st_cnt_q <= rst_b_i ? st_cnt_d : 0;
      slp_q <= rst_b_i ? slp_d : 1'b0;
   end
   supply_off_a: assert property ((!supply_ok_i)[*3] |-> ##[1:5] mode_o == PMS_OFF
      && !regulators_en_o) else $error("supply loss did not force off");
   idle_ctl_a: assert property (mode_o == PMS_IDLE |-> slow_clk_sel_o
      && !periph_access_en_o && !lin_en_o) else $error("idle controls wrong");
   idle_wake_a: assert property ((mode_o == PMS_IDLE && ext_irq_i)[*3]
      |-> ##[1:6] mode_o != PMS_IDLE) else $error("interrupt did not end idle");
   stop_osc_a: assert property (mode_o == PMS_STOP
      |-> !main_rc_oscillator_en_o && !lin_en_o) else $error("stop controls wrong");
   sleep_entry_a: assert property (supply_ok_i[*6] ##0 (mode_o == PMS_NORMAL
      && sleep_req_i) |=> mode_o == PMS_SLEEP && !cpu_pwr_en_o) else $error("no sleep entry");
   irq_or_a: assert property (extended_irq_o == (undervoltage_flag_o
      || overvoltage_flag_o)) else $error("interrupt not the flag sum");
   uv_sticky_a: assert property ($fell(undervoltage_flag_o) |-> $past(uv_clr_i)
      || mode_o inside {PMS_OFF, PMS_START}) else $error("flag lost without clear");
   level_rst_a: assert property (mode_o == PMS_START
      |-> undervoltage_level_select_o == UV_SEL_RST) else $error("level not reset");
   uv_deb_a: assert property ($rose(undervoltage_flag_o) |-> uv_run_q >= UV_CYCLES)
      else $error("under-voltage flag too early");
   ov_deb_a: assert property ($rose(overvoltage_flag_o) |-> ov_run_q >= OV_CYCLES)
      else $error("over-voltage flag too early");
   start_len_a: assert property (mode_o == PMS_START
      |-> st_cnt_q < (slp_q ? SLP_CYCLES : POR_CYCLES)) else $error("startup too long");
   sleep_exit_a: assert property ($past(mode_o) == PMS_SLEEP && mode_o != PMS_SLEEP
      |-> mode_o inside {PMS_START, PMS_OFF}) else $error("sleep left without startup");
   cover property (mode_o == PMS_SLEEP ##1 mode_o == PMS_START);
   cover property ($rose(undervoltage_flag_o));
   cover property ($rose(overvoltage_flag_o));
endmodule // pms_checker
bind pms_top pms_checker #(.UV_CYCLES(UV_CYCLES), .OV_CYCLES(OV_CYCLES),
   .POR_CYCLES(POR_CYCLES), .SLP_CYCLES(SLP_CYCLES)) chk (.mclk_i, .rst_b_i, .supply_ok_i,
   .uv_det_i, .ov_det_i, .ext_irq_i, .sleep_req_i, .uv_clr_i, .regulators_en_o, .cpu_pwr_en_o,
   .main_rc_oscillator_en_o, .slow_clk_sel_o, .periph_access_en_o, .lin_en_o, .mode_o,
   .undervoltage_level_select_o, .undervoltage_flag_o, .overvoltage_flag_o, .extended_irq_o);

// *** test/pms_lin_peer.sv ***
// Purpose: LIN bus wake source facing the supervisor
// Assumes: Bench asks for a dominant stretch of a given cycle count
// Notes:   Bus pull-up gives recessive whenever nothing drives
module pms_lin_peer
(
   // Clock
   input wire logic mclk_i,
   // Command from the bench
   input wire logic go_i,
   input wire logic [15:0] len_i,
   // Bus receive level, low is dominant
   output logic lin_rx_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] cnt_q = 16'h0;
   logic [15:0] cnt_d;
   // Remaining dominant cycles
   always_comb
   begin
      cnt_d = go_i ? len_i : (cnt_q != 16'h0 ? cnt_q - 16'h1 : cnt_q);
   end
   always_ff @(posedge mclk_i)
   begin
      cnt_q <= cnt_d;
   end
   assign lin_rx_o = (cnt_q == 16'h0);
endmodule // pms_lin_peer

// *** test/pms_top_tb.sv ***
// Purpose: Self-checking bench for the power-mode supervisor
// Assumes: Debounce and startup counts shortened by parameters
// Notes:   LIN wake comes from the peer model, all else from tasks and the initial block here
module pms_top_tb
   import pms_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int unsigned UV_N = 50;
   localparam int unsigned OV_N = 20;
   localparam int unsigned HV_N = 20;
   localparam int unsigned POR_N = 30;
   localparam int unsigned SLP_N = 15;
   logic mclk_i = 1'b0;
   logic rst_b_i, supply_ok_i, uv_det_i, ov_det_i, ext_irq_i, lin_go, lin_rx;
   logic [5:0] req;
   logic [2:0] uv_level_i, undervoltage_level_select_o;
   logic [15:0] lin_len;
   logic [HV_PINS-1:0] high_voltage_pins_i;
   logic regulators_en_o, cpu_pwr_en_o, digital_rst_b_o, main_rc_oscillator_en_o;
   logic slow_clk_sel_o, periph_access_en_o, lin_en_o, auxiliary_wake_supply_only_o;
   logic undervoltage_flag_o, overvoltage_flag_o, extended_irq_o;
   pms_mode_t mode_o;
   int error_cnt = 0;
   int checked = 0;
   always #2.5 mclk_i = ~mclk_i;
   pms_top #(.UV_CYCLES(UV_N), .OV_CYCLES(OV_N), .HVWK_CYCLES(HV_N), .POR_CYCLES(POR_N),
      .SLP_CYCLES(SLP_N)) dut (.mclk_i, .rst_b_i, .supply_ok_i, .uv_det_i, .ov_det_i,
      .lin_rx_i(lin_rx), .high_voltage_pins_i, .ext_irq_i, .idle_req_i(req[0]),
      .stop_req_i(req[1]), .sleep_req_i(req[2]), .uv_clr_i(req[3]), .ov_clr_i(req[4]),
      .uv_level_wr_i(req[5]), .uv_level_i, .regulators_en_o, .cpu_pwr_en_o, .digital_rst_b_o,
      .main_rc_oscillator_en_o, .slow_clk_sel_o, .periph_access_en_o, .lin_en_o,
      .auxiliary_wake_supply_only_o, .mode_o, .undervoltage_level_select_o,
      .undervoltage_flag_o, .overvoltage_flag_o, .extended_irq_o);
   pms_lin_peer peer (.mclk_i, .go_i(lin_go), .len_i(lin_len), .lin_rx_o(lin_rx));
   task automatic close_out();
      if (error_cnt == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic step(int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask
   task automatic chk(string name, logic [2:0] exp, logic [2:0] got);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Bounded wait for a mode; a miss ends the run
   task automatic wait_mode(pms_mode_t m, int n);
      int i;
      #1;
      for (i = 0; i < n && mode_o !== m; i++) step(1);
      chk("mode", m, mode_o);
      if (mode_o !== m)
         close_out();
   endtask
   // One-cycle software request on bit k
   task automatic pulse(int k);
      @(posedge mclk_i) req <= 6'h1 << k;
      @(posedge mclk_i) req <= 6'h0;
      #1;
   endtask
   task automatic irq_wake();
      @(posedge mclk_i) ext_irq_i <= 1'b1;
      wait_mode(PMS_NORMAL, 8);
      @(posedge mclk_i) ext_irq_i <= 1'b0;
      step(6);
   endtask
   task automatic lin_dom(logic [15:0] len);
      @(posedge mclk_i) lin_len <= len;
      lin_go <= 1'b1;
      @(posedge mclk_i) lin_go <= 1'b0;
   endtask
   // Sets a line high for n + 1 cycles, or for good when n is 0
   task automatic pin_wake(logic [3:0] v, int n);
      @(posedge mclk_i) high_voltage_pins_i <= v;
      if (n > 0)
      begin
         step(n);
         @(posedge mclk_i) high_voltage_pins_i <= 4'h0;
      end
   endtask
   initial
   begin
      {rst_b_i, uv_det_i, ov_det_i, ext_irq_i, lin_go} = 5'h0;
      supply_ok_i = 1'b1;
      req = 6'h0;
      uv_level_i = 3'h0;
      lin_len = 16'h0;
      high_voltage_pins_i = 4'h0;
      step(4);
      chk("mode", PMS_OFF, mode_o);
      chk("regulators", 1'b0, regulators_en_o);
      chk("level", UV_SEL_RST, undervoltage_level_select_o);
      @(posedge mclk_i) rst_b_i <= 1'b1;
      wait_mode(PMS_START, 8);
      wait_mode(PMS_NORMAL, POR_N + 1);
      chk("dig_rst", 1'b1, digital_rst_b_o);
      @(posedge mclk_i) uv_level_i <= UV_SEL_7V0;
      pulse(5);
      chk("level", UV_SEL_7V0, undervoltage_level_select_o);
      @(posedge mclk_i) uv_level_i <= UV_SEL_8V5;
      pulse(5);
      chk("level", UV_SEL_8V5, undervoltage_level_select_o);
      pulse(0);
      wait_mode(PMS_IDLE, 2);
      chk("slow_clk", 1'b1, slow_clk_sel_o);
      chk("periph", 1'b0, periph_access_en_o);
      chk("lin_en", 1'b0, lin_en_o);
      pulse(2);
      chk("mode", PMS_IDLE, mode_o);
      irq_wake();
      pulse(1);
      wait_mode(PMS_STOP, 2);
      chk("osc", 1'b0, main_rc_oscillator_en_o);
      chk("lin_en", 1'b0, lin_en_o);
      irq_wake();
      @(posedge mclk_i) uv_det_i <= 1'b1;
      step(UV_N - 1);
      chk("uv_flag", 1'b0, undervoltage_flag_o);
      step(12);
      chk("uv_flag", 1'b1, undervoltage_flag_o);
      chk("irq", 1'b1, extended_irq_o);
      chk("mode", PMS_NORMAL, mode_o);
      @(posedge mclk_i) uv_det_i <= 1'b0;
      pulse(3);
      chk("uv_flag", 1'b0, undervoltage_flag_o);
      @(posedge mclk_i) ov_det_i <= 1'b1;
      step(OV_N / 2);
      @(posedge mclk_i) ov_det_i <= 1'b0;
      step(OV_N + 8);
      chk("ov_flag", 1'b0, overvoltage_flag_o);
      @(posedge mclk_i) ov_det_i <= 1'b1;
      step(OV_N + 12);
      chk("ov_flag", 1'b1, overvoltage_flag_o);
      chk("irq", 1'b1, extended_irq_o);
      @(posedge mclk_i) ov_det_i <= 1'b0;
      pulse(4);
      chk("ov_flag", 1'b0, overvoltage_flag_o);
      pulse(2);
      wait_mode(PMS_SLEEP, 2);
      chk("cpu_pwr", 1'b0, cpu_pwr_en_o);
      chk("aux_only", 1'b1, auxiliary_wake_supply_only_o);
      lin_dom(16'h0064);
      step(130);
      chk("mode", PMS_SLEEP, mode_o);
      lin_dom(16'h0BDC);
      step(2990);
      chk("mode", PMS_SLEEP, mode_o);
      wait_mode(PMS_START, 30);
      wait_mode(PMS_NORMAL, SLP_N + 1);
      chk("periph", 1'b1, periph_access_en_o);
      step(40);
      pulse(2);
      wait_mode(PMS_SLEEP, 2);
      pin_wake(4'h1, HV_N / 2);
      step(HV_N + 8);
      chk("mode", PMS_SLEEP, mode_o);
      pin_wake(4'h8, 0);
      wait_mode(PMS_START, HV_N + 10);
      wait_mode(PMS_NORMAL, SLP_N + 1);
      @(posedge mclk_i) supply_ok_i <= 1'b0;
      wait_mode(PMS_OFF, 8);
      chk("regulators", 1'b0, regulators_en_o);
      step(6);
      close_out();
   end
endmodule // pms_top_tb
